// >>> hdl/fpt_regs.svh
// Purpose: Register offsets, field positions, reset values and timing
//          counts of the flash protection and timing controller.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef FPT_REGS_SVH
`define FPT_REGS_SVH

// -------------------------------------------------------------------
// Register offsets
// -------------------------------------------------------------------
`define FPT_OFS_ADDR 12'h000
`define FPT_OFS_DATA 12'h004
`define FPT_OFS_CTRL 12'h008
`define FPT_OFS_RIS 12'h00C
`define FPT_OFS_MASK 12'h010
`define FPT_OFS_MIS 12'h014
`define FPT_OFS_USEC 12'h140
`define FPT_OFS_RE0 12'h200
`define FPT_OFS_RE1 12'h204
`define FPT_OFS_PE0 12'h400
`define FPT_OFS_PE1 12'h404

// -------------------------------------------------------------------
// Fields
// -------------------------------------------------------------------
`define FPT_KEY 16'hA442
`define FPT_BIT_WRITE 0
`define FPT_BIT_ERASE 1
`define FPT_BIT_MERASE 2
`define FPT_BIT_COMMIT 3
`define FPT_BIT_AV 0
`define FPT_BIT_DONE 1

// -------------------------------------------------------------------
// Commit targets held in the flash address register
// -------------------------------------------------------------------
`define FPT_CMT_RE0 17'h00000
`define FPT_CMT_PE0 17'h00001
`define FPT_CMT_RE1 17'h00002
`define FPT_CMT_PE1 17'h00003

// -------------------------------------------------------------------
// Reset values and geometry
// -------------------------------------------------------------------
`define FPT_USEC_RST 8'h16
`define FPT_POL0_FACTORY 32'hFFFFFFFF
`define FPT_POL1_FACTORY 32'h0000FFFF
`define FPT_UNITS 6'h30
`define FPT_LAST_WORD 15'h5FFF

// -------------------------------------------------------------------
// Timing, in microseconds of the reload tick
// -------------------------------------------------------------------
`define FPT_PROG_US 20
`define FPT_ERASE_US 20000

`endif

// >>> hdl/fpt_pkg.sv
// Purpose: Types shared by the flash protection and timing controller.
// Assumes: Compiled before the design modules.
// Notes:   Offsets and counts live in fpt_regs.svh.
package fpt_pkg;

   typedef enum logic [2:0] {
      fpt_st_idle = 3'h0,
      fpt_st_wait = 3'h1,
      fpt_st_prog = 3'h2,
      fpt_st_erase = 3'h3,
      fpt_st_commit = 3'h4
   } fpt_state_t;

   typedef enum logic [1:0] {
      fpt_src_fetch = 2'h0,
      fpt_src_data = 2'h1,
      fpt_src_debug = 2'h2
   } fpt_src_t;

endpackage

// >>> hdl/fpt_usec_tick.sv
// Purpose: One-cycle tick every (reload + 1) system clocks.
// Assumes: Reload is static while flash operations run.
// Notes:   A new reload takes effect at the next wrap.
`timescale 1ns/1ps
`default_nettype none
module fpt_usec_tick
   import fpt_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reload_i,
   output logic tick_o
);

   logic [7:0] count;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count <= 8'h00;
         tick_o <= 1'b0;
      end else if (count == 8'h00) begin
         count <= reload_i;
         tick_o <= 1'b1;
      end else begin
         count <= count - 8'h01;
         tick_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// >>> hdl/fpt_flash_array.sv
// Purpose: 96 KB flash array of 32-bit words, one read and one write port.
// Assumes: Caller never programs and erases the same word in one cycle.
// Notes:   A read that is not enabled returns zero, so blocked reads fill 0s.
`timescale 1ns/1ps
`default_nettype none
module fpt_flash_array
   import fpt_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic rd_en_i,
   input wire logic [14:0] rd_addr_i,
   output logic [31:0] rd_data_o,
   input wire logic prog_i,
   input wire logic erase_i,
   input wire logic [14:0] wr_addr_i,
   input wire logic [31:0] wr_data_i
);

   logic [31:0] mem [0:24575];

   // ----------------------------------------------------------------
   // Write port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (erase_i) begin
         mem[wr_addr_i] <= 32'hFFFFFFFF;
      end else if (prog_i) begin
         mem[wr_addr_i] <= mem[wr_addr_i] & wr_data_i;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_o <= 32'h00000000;
      end else if (rd_en_i) begin
         rd_data_o <= mem[rd_addr_i];
      end else begin
         rd_data_o <= 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// >>> hdl/fpt_ctrl.sv
// Purpose: Flash protection and operation timing controller, top level.
// Assumes: Register master per plain strobe port; one flash access port
//          shared by instruction fetch, data side bus and debugger.
// Notes:   Committed policy sits on factory_rst_b_i, not on rst_b_i.
`include "fpt_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fpt_ctrl
   import fpt_pkg::*;
#(
   parameter int unsigned PROG_US = `FPT_PROG_US,
   parameter int unsigned ERASE_US = `FPT_ERASE_US
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic factory_rst_b_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic acc_req_i,
   input wire logic [1:0] acc_src_i,
   input wire logic [16:0] acc_addr_i,
   output logic [31:0] acc_rdata_o,
   output logic acc_viol_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   fpt_state_t state;
   logic [16:0] flash_addr;
   logic [31:0] flash_data;
   logic [3:0] op_q;
   logic [7:0] usec_reload_value;
   logic [31:0] re0, re1, pe0, pe1;
   logic [31:0] cre0, cre1, cpe0, cpe1;
   logic load_pend;
   logic [1:0] flash_irq_mask_reg;
   logic [1:0] raw_flags;
   logic [15:0] us_cnt;
   logic [14:0] wcnt, wend;
   logic usec_tick;
   logic [47:0] read_enable_policy, program_enable_policy;
   logic [5:0] fa_unit, acc_unit;
   logic fa_ok, prog_ok, acc_ok, acc_rd_ok;
   logic ctrl_wr, op_write, op_erase, op_merase, op_commit;
   logic av_prog, av_read, acc_allow, op_done;
   logic wr_prog, wr_erase;
   logic [1:0] flag_set, flag_clr;

   // ----------------------------------------------------------------
   // Policy lookup
   // ----------------------------------------------------------------
   // Upper half of the second register pair is unimplemented
   assign read_enable_policy = {re1[15:0], re0};
   assign program_enable_policy = {pe1[15:0], pe0};

   assign fa_unit = flash_addr[16:11];
   assign fa_ok = fa_unit < `FPT_UNITS;
   assign prog_ok = fa_ok && program_enable_policy[fa_unit];

   assign acc_unit = acc_addr_i[16:11];
   assign acc_ok = acc_unit < `FPT_UNITS;
   assign acc_rd_ok = acc_ok && read_enable_policy[acc_unit];
   // Fetch passes regardless of read-enable
   assign acc_allow = acc_req_i && acc_ok &&
      (acc_src_i == fpt_src_fetch || acc_rd_ok);
   assign av_read = acc_req_i && acc_ok &&
      acc_src_i != fpt_src_fetch && !acc_rd_ok;

   // ----------------------------------------------------------------
   // Control word decode
   // ----------------------------------------------------------------
   // Writes without the key, or while busy, are dropped silently
   assign ctrl_wr = reg_wr_i && reg_addr_i == `FPT_OFS_CTRL &&
      reg_wdata_i[31:16] == `FPT_KEY && state == fpt_st_idle;
   assign op_write = ctrl_wr && reg_wdata_i[`FPT_BIT_WRITE];
   assign op_erase = ctrl_wr && !reg_wdata_i[`FPT_BIT_WRITE] &&
      reg_wdata_i[`FPT_BIT_ERASE];
   assign op_merase = ctrl_wr && !reg_wdata_i[`FPT_BIT_WRITE] &&
      !reg_wdata_i[`FPT_BIT_ERASE] && reg_wdata_i[`FPT_BIT_MERASE];
   assign op_commit = ctrl_wr && reg_wdata_i[3:0] == 4'h8;
   assign av_prog = (op_write || op_erase) && fa_ok &&
      !program_enable_policy[fa_unit];

   // ----------------------------------------------------------------
   // Microsecond tick
   // ----------------------------------------------------------------
   fpt_usec_tick u_tick (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .reload_i(usec_reload_value),
      .tick_o(usec_tick)
   );

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= fpt_st_idle;
         op_q <= 4'h0;
         us_cnt <= 16'h0000;
         wcnt <= 15'h0000;
         wend <= 15'h0000;
      end else begin
         case (state)
            fpt_st_idle: begin
               if (op_write && prog_ok) begin
                  op_q <= 4'h1;
                  us_cnt <= 16'(PROG_US);
                  state <= fpt_st_wait;
               end else if (op_erase && prog_ok) begin
                  op_q <= 4'h2;
                  us_cnt <= 16'(ERASE_US);
                  wcnt <= {flash_addr[16:10], 8'h00};
                  wend <= {flash_addr[16:10], 8'hFF};
                  state <= fpt_st_wait;
               end else if (op_merase) begin
                  op_q <= 4'h4;
                  us_cnt <= 16'(ERASE_US);
                  wcnt <= 15'h0000;
                  wend <= `FPT_LAST_WORD;
                  state <= fpt_st_wait;
               end else if (op_commit) begin
                  op_q <= 4'h8;
                  us_cnt <= 16'(PROG_US);
                  state <= fpt_st_wait;
               end
            end
            fpt_st_wait: begin
               if (usec_tick) begin
                  if (us_cnt <= 16'h0001) begin
                     if (op_q[`FPT_BIT_WRITE]) begin
                        state <= fpt_st_prog;
                     end else if (op_q[`FPT_BIT_COMMIT]) begin
                        state <= fpt_st_commit;
                     end else begin
                        state <= fpt_st_erase;
                     end
                  end else begin
                     us_cnt <= us_cnt - 16'h0001;
                  end
               end
            end
            fpt_st_prog: begin
               op_q <= 4'h0;
               state <= fpt_st_idle;
            end
            fpt_st_erase: begin
               // One word per cycle keeps the array a plain RAM
               if (wcnt == wend) begin
                  op_q <= 4'h0;
                  state <= fpt_st_idle;
               end else begin
                  wcnt <= wcnt + 15'h0001;
               end
            end
            fpt_st_commit: begin
               op_q <= 4'h0;
               state <= fpt_st_idle;
            end
            default: begin
               op_q <= 4'h0;
               state <= fpt_st_idle;
            end
         endcase
      end
   end

   assign op_done = (state == fpt_st_prog) ||
      (state == fpt_st_commit) ||
      (state == fpt_st_erase && wcnt == wend);

   // ----------------------------------------------------------------
   // Flash array
   // ----------------------------------------------------------------
   assign wr_prog = state == fpt_st_prog;
   // Mass erase skips units whose program-enable is clear
   assign wr_erase = state == fpt_st_erase &&
      program_enable_policy[wcnt[14:9]];

   fpt_flash_array u_array (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .rd_en_i(acc_allow),
      .rd_addr_i(acc_addr_i[16:2]),
      .rd_data_o(acc_rdata_o),
      .prog_i(wr_prog),
      .erase_i(wr_erase),
      .wr_addr_i(wr_erase ? wcnt : flash_addr[16:2]),
      .wr_data_i(flash_data)
   );

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_viol_o <= 1'b0;
      end else begin
         acc_viol_o <= av_read;
      end
   end

   // ----------------------------------------------------------------
   // Committed policy, survives rst_b_i
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge factory_rst_b_i) begin
      if (!factory_rst_b_i) begin
         cre0 <= `FPT_POL0_FACTORY;
         cre1 <= `FPT_POL1_FACTORY;
         cpe0 <= `FPT_POL0_FACTORY;
         cpe1 <= `FPT_POL1_FACTORY;
      end else if (state == fpt_st_commit) begin
         // Nonvolatile bits only ever go from one to zero
         case (flash_addr)
            `FPT_CMT_RE0: cre0 <= cre0 & re0;
            `FPT_CMT_RE1: cre1 <= cre1 & re1;
            `FPT_CMT_PE0: cpe0 <= cpe0 & pe0;
            `FPT_CMT_PE1: cpe1 <= cpe1 & pe1;
            default: cre0 <= cre0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Working policy
   // ----------------------------------------------------------------
   // Everything reads as locked for the one cycle before the reload
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         load_pend <= 1'b1;
         re0 <= 32'h00000000;
         re1 <= 32'h00000000;
         pe0 <= 32'h00000000;
         pe1 <= 32'h00000000;
      end else if (load_pend) begin
         load_pend <= 1'b0;
         re0 <= cre0;
         re1 <= cre1;
         pe0 <= cpe0;
         pe1 <= cpe1;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `FPT_OFS_RE0: re0 <= reg_wdata_i;
            `FPT_OFS_RE1: re1 <= reg_wdata_i & `FPT_POL1_FACTORY;
            `FPT_OFS_PE0: pe0 <= reg_wdata_i;
            `FPT_OFS_PE1: pe1 <= reg_wdata_i & `FPT_POL1_FACTORY;
            default: re0 <= re0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Plain control registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flash_addr <= 17'h00000;
         flash_data <= 32'h00000000;
         flash_irq_mask_reg <= 2'h0;
         usec_reload_value <= `FPT_USEC_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `FPT_OFS_ADDR: flash_addr <= reg_wdata_i[16:0];
            `FPT_OFS_DATA: flash_data <= reg_wdata_i;
            `FPT_OFS_MASK: flash_irq_mask_reg <= reg_wdata_i[1:0];
            `FPT_OFS_USEC: usec_reload_value <= reg_wdata_i[7:0];
            default: flash_data <= flash_data;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status flags and interrupt
   // ----------------------------------------------------------------
   assign flag_set = {op_done, av_prog || av_read};
   assign flag_clr = (reg_wr_i && reg_addr_i == `FPT_OFS_MIS) ?
      reg_wdata_i[1:0] : 2'h0;

   // A new event in the clearing cycle keeps its flag
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         raw_flags <= 2'h0;
      end else begin
         raw_flags <= flag_set | (raw_flags & ~flag_clr);
      end
   end

   assign irq_o = |(raw_flags & flash_irq_mask_reg);

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `FPT_OFS_ADDR: reg_rdata_o <= {15'h0000, flash_addr};
            `FPT_OFS_DATA: reg_rdata_o <= flash_data;
            `FPT_OFS_CTRL: reg_rdata_o <= {28'h0000000, op_q};
            `FPT_OFS_RIS: reg_rdata_o <= {30'h00000000, raw_flags};
            `FPT_OFS_MASK: reg_rdata_o <= {30'h00000000, flash_irq_mask_reg};
            `FPT_OFS_MIS: reg_rdata_o <=
               {30'h00000000, raw_flags & flash_irq_mask_reg};
            `FPT_OFS_USEC: reg_rdata_o <= {24'h000000, usec_reload_value};
            `FPT_OFS_RE0: reg_rdata_o <= re0;
            `FPT_OFS_RE1: reg_rdata_o <= re1;
            `FPT_OFS_PE0: reg_rdata_o <= pe0;
            `FPT_OFS_PE1: reg_rdata_o <= pe1;
            default: reg_rdata_o <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_o <= 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// >>> tb/fpt_ctrl_asserts.sv
// Purpose: Port-level assertions for the flash protection controller.
// Assumes: One clock domain; rst_b_i is asynchronous and active low.
// Notes:   Bound into every fpt_ctrl instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module fpt_ctrl_asserts #(
   parameter int unsigned PROG_US = 20,
   parameter int unsigned ERASE_US = 20000
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic factory_rst_b_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic acc_req_i,
   input wire logic [1:0] acc_src_i,
   input wire logic [16:0] acc_addr_i,
   input wire logic [31:0] acc_rdata_o,
   input wire logic acc_viol_o,
   input wire logic irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence rd_at(a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   sequence wr_at(a);
      reg_wr_i && reg_addr_i == a;
   endsequence
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   blocked_zero_a: assert property (acc_viol_o |-> acc_rdata_o == 32'h0)
      else $error("blocked read carried data");
   fetch_open_a: assert property (
      acc_req_i && acc_src_i == 2'h0 |=> !acc_viol_o)
      else $error("fetch was refused");
   viol_cause_a: assert property (
      acc_viol_o |-> $past(acc_req_i) && $past(acc_src_i) != 2'h0)
      else $error("violation without a data or debug read");
   idle_quiet_a: assert property (
      !$past(acc_req_i) |-> acc_rdata_o == 32'h0 && !acc_viol_o)
      else $error("access output without request");
   rd_window_a: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data outside its cycle");
   upper_units_a: assert property (
      reg_rd_i && (reg_addr_i == 12'h204 || reg_addr_i == 12'h404)
      |=> reg_rdata_o[31:16] == 16'h0)
      else $error("unit beyond the array reported");
   reload_back_a: assert property (
      wr_at(12'h140) ##1 !reg_wr_i ##1 rd_at(12'h140)
      |=> reg_rdata_o[7:0] == $past(reg_wdata_i[7:0], 3))
      else $error("reload value not kept");
   irq_mask_a: assert property (
      rd_at(12'h014) |=> (|reg_rdata_o) == $past(irq_o))
      else $error("interrupt differs from masked status");
   sticky_flag_a: assert property (
      acc_viol_o && !reg_wr_i ##1 rd_at(12'h00C) |=> reg_rdata_o[0])
      else $error("violation flag not set");
endmodule
bind fpt_ctrl fpt_ctrl_asserts #(.PROG_US(PROG_US), .ERASE_US(ERASE_US))
   fpt_ctrl_asserts_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
   .factory_rst_b_i(factory_rst_b_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .acc_req_i(acc_req_i),
   .acc_src_i(acc_src_i), .acc_addr_i(acc_addr_i),
   .acc_rdata_o(acc_rdata_o), .acc_viol_o(acc_viol_o), .irq_o(irq_o));
`default_nettype wire

// >>> tb/fpt_flash_master.sv
// Purpose: Fetch, data and debug masters reading the flash.
// Assumes: One read at a time, answer one cycle after the request.
// Notes:   Released lines are inverted so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module fpt_flash_master (
   input wire logic core_clk_i,
   output logic acc_req_o,
   output logic [1:0] acc_src_o,
   output logic [16:0] acc_addr_o,
   input wire logic [31:0] acc_rdata_i,
   input wire logic acc_viol_i
);
   initial begin
      acc_req_o = 1'b0;
      acc_src_o = 2'h0;
      acc_addr_o = 17'h0;
   end
   task automatic read(input logic [1:0] src, input logic [16:0] addr,
      output logic [31:0] data, output logic viol);
      @(posedge core_clk_i);
      acc_req_o <= 1'b1;
      acc_src_o <= src;
      acc_addr_o <= addr;
      @(posedge core_clk_i);
      acc_req_o <= 1'b0;
      acc_src_o <= ~src;
      acc_addr_o <= ~addr;
      @(negedge core_clk_i);
      data = acc_rdata_i;
      viol = acc_viol_i;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the flash protection controller.
// Assumes: Short operation counts; reload at 50 MHz is 0x31.
// Notes:   Every flash page read back is erased first.
`timescale 1ns/1ps
`default_nettype none
module tb_top import fpt_pkg::*;;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic factory_rst_b_i = 1'b0;
   logic [11:0] reg_addr_i = 12'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o, acc_rdata_o;
   logic acc_req_i, acc_viol_o, irq_o;
   logic [1:0] acc_src_i;
   logic [16:0] acc_addr_i;
   int error_cnt = 0;
   int total_checks = 0;
   int seed = 32'h9AAD37F5;
   int ul [5] = '{0, 1, 2, 3, 40};
   logic [31:0] wre [2], wpe [2], cre [2], cpe [2];
   logic [31:0] mem [int];
   always #10 core_clk_i = ~core_clk_i;
   fpt_ctrl #(.PROG_US(2), .ERASE_US(3)) fpt_ctrl_inst (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .factory_rst_b_i(factory_rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .acc_req_i(acc_req_i),
      .acc_src_i(acc_src_i), .acc_addr_i(acc_addr_i),
      .acc_rdata_o(acc_rdata_o), .acc_viol_o(acc_viol_o), .irq_o(irq_o));
   fpt_flash_master fpt_flash_master_inst (.core_clk_i(core_clk_i),
      .acc_req_o(acc_req_i), .acc_src_o(acc_src_i),
      .acc_addr_o(acc_addr_i), .acc_rdata_i(acc_rdata_o),
      .acc_viol_i(acc_viol_o));
   // ----------------------------------------------------------------
   // Compare, bus and model tasks
   // ----------------------------------------------------------------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_acc(input logic [31:0] gd, input logic gv,
      input logic [31:0] ed, input logic ev);
      total_checks++;
      if ({gv, gd} !== {ev, ed}) begin
         error_cnt++;
         $display("CHECK FAILED %0t acc %b %h exp %b %h", $time, gv, gd,
            ev, ed);
      end
   endtask
   task automatic chk_irq(input logic e);
      @(negedge core_clk_i);
      chk_reg({31'h0, irq_o}, {31'h0, e});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      d = reg_rdata_o;
   endtask
   task automatic check_pol();
      logic [31:0] d;
      for (int i = 0; i < 4; i++) begin
         rd((i < 2 ? 12'h200 : 12'h400) + 12'(i % 2 * 4), d);
         chk_reg(d, i < 2 ? wre[i % 2] : wpe[i % 2]);
      end
   endtask
   // Program (1), page erase (2), mass erase (4) or commit (8), then poll
   task automatic op(input logic [16:0] a, input logic [31:0] d, input int c);
      logic [31:0] s;
      int u;
      int n;
      u = a / 2048;
      n = 0;
      wr(12'h000, {15'h0, a});
      wr(12'h004, d);
      wr(12'h008, {16'hA442, 16'(c)});
      do begin
         rd(12'h008, s);
         n++;
      end while (s !== 32'h0 && n < 15000);
      chk_reg(s, 32'h0);
      if (c == 8) begin
         if (a[0])
            cpe[a[1]] &= wpe[a[1]];
         else
            cre[a[1]] &= wre[a[1]];
      end else if (c == 4) begin
         // Mass erase leaves units without program-enable alone
         for (int i = 0; i < 24576; i++)
            if (wpe[i / 16384][i / 512 % 32])
               mem[i] = '1;
      end else if (wpe[u / 32][u % 32]) begin
         if (c == 1)
            mem[a / 4] &= d;
         else
            for (int i = 0; i < 256; i++) mem[a / 1024 * 256 + i] = '1;
      end else begin
         rd(12'h00C, s);
         chk_reg(s & 32'h1, 32'h1);
         wr(12'h014, 32'h1);
      end
   endtask
   task automatic acc(input logic [1:0] src, input logic [16:0] a);
      logic [31:0] d;
      logic v;
      logic ok;
      int u;
      u = a / 2048;
      ok = (a < 17'h18000);
      fpt_flash_master_inst.read(src, a, d, v);
      if (ok && src != 2'h0 && !wre[u / 32][u % 32])
         chk_acc(d, v, 32'h0, 1'b1);
      else
         chk_acc(d, v, ok ? mem[a / 4] : 32'h0, 1'b0);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [31:0] r;
      wre = '{32'hFFFFFFFF, 32'h0000FFFF};
      wpe = wre;
      cre = wre;
      cpe = wre;
      repeat (8) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      factory_rst_b_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      check_pol();
      rd(12'h140, d);
      chk_reg(d, 32'h16);
      rd(12'h7FC, d);
      chk_reg(d, 32'h0);
      wr(12'h140, 32'h31);
      rd(12'h140, d);
      chk_reg(d, 32'h31);
      foreach (ul[i])
         op(17'(ul[i] * 2048), 32'h0, 2);
      r = $random(seed);
      d = $random(seed);
      op(17'h4, r, 1);
      op(17'h4, d, 1);
      acc(2'h1, 17'h4);
      op(17'h804, r, 1);
      op(17'h1004, r, 1);
      op(17'h0, 32'h0, 2);
      acc(2'h1, 17'h4);
      acc(2'h2, 17'h804);
      wre[0] = 32'hFFFFFFF5;
      wpe[0] = 32'hFFFFFFF3;
      wre[1] = 32'h0000FEFF;
      wr(12'h200, wre[0]);
      wr(12'h400, wpe[0]);
      wr(12'h204, 32'hFFFFFEFF);
      check_pol();
      op(17'h808, r, 1);
      op(17'h1008, r, 1);
      op(17'h1800, 32'h0, 2);
      op(17'h0, 32'h0, 4);
      acc(2'h0, 17'h1004);
      foreach (ul[i])
         for (int s = 0; s < 3; s++)
            acc(2'(s), 17'(ul[i] * 2048 + 8));
      acc(2'h1, 17'h18000);
      wr(12'h010, 32'h1);
      chk_irq(1'b1);
      rd(12'h014, d);
      chk_reg(d, 32'h1);
      wr(12'h014, 32'h1);
      chk_irq(1'b0);
      acc(2'h2, 17'h1808);
      rd(12'h00C, d);
      chk_reg(d & 32'h1, 32'h1);
      chk_irq(1'b1);
      wr(12'h014, 32'h1);
      op(17'h0, 32'h0, 8);
      @(posedge core_clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      wre = cre;
      wpe = cpe;
      check_pol();
      op(17'h100C, r, 1);
      acc(2'h0, 17'h100C);
      acc(2'h1, 17'h1808);
      end_of_test();
   end
   // Less than twice the expected run, most of it mass erase; a hang still ends with a verdict
   initial begin
      #1000000;
      error_cnt++;
      end_of_test();
   end
endmodule
`default_nettype wire
